// *** sadc_ctrl.sv ***
`timescale 1ns/100ps
`include "sadc_params.svh"

// Result buffer between the converter core and the output register.
module sadc_fifo #(
  parameter int WIDTH = `SADC_RES_DEFAULT,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic in_valid_in, // Write request.
  output logic in_ready_out, // Space available.
  input wire logic [WIDTH-1:0] in_data_in, // Write data.
  output logic out_valid_out, // Data available.
  input wire logic out_ready_in, // Read acknowledge.
  output logic [WIDTH-1:0] out_data_out, // Head of queue.
  output logic [$clog2(DEPTH+1)-1:0] level_out // Entries held.
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("sadc_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [LW-1:0] cnt;
  } sadc_fifo_st_t;

  sadc_fifo_st_t r_reg;
  sadc_fifo_st_t r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Full and empty come straight from the count, so neither lies.
  assign in_ready_out = (r_reg.cnt != LW'(DEPTH));
  assign out_valid_out = (r_reg.cnt != '0);
  assign out_data_out = mem[r_reg.rd];
  assign level_out = r_reg.cnt;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Pointer and count update.
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = r_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  // Storage carries no reset; only the pointers and the count need a defined start.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
    if (push) begin
      mem[r_reg.wr] <= in_data_in;
    end
  end
endmodule

// Behaviour
// - The result bus is driven only once select and read are both low.
// - Select and read meet in one AND, so either may gate the bus.
// - With both held low the bus stays driven and a new result shows before busy falls.
// - A falling start strobe moves track/hold to hold and starts conversion.
// - Start still low when busy falls puts the part to sleep at that edge.
// - In sleep the next rising start edge wakes the part, ready after about 1 us.
// - A conversion takes 14 conversion clocks at 12 bits and 12 at 10 bits.
// - The conversion clock pad is closed whenever no conversion runs.
// - Busy rises after the start edge and stays high for the conversion.
// - Busy falls only after the result sits in the output register.
// - Track resumes just before busy falls; acquisition begins as it falls.
// - The result leaves on a three-state bus of 10 or 12 bits.
// - The result is unsigned straight binary from the approximation.
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int RES = `SADC_RES_DEFAULT,
  parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
  input wire logic clk_sys_in, // System clock, 50 MHz.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic conversion_start_n_in, // Start strobe, active low.
  input wire logic conv_clk_in, // Conversion clock from host.
  input wire logic select_n_in, // Select, active low.
  input wire logic read_n_in, // Read strobe, active low.
  input wire logic [RES-1:0] analog_code_in, // Quantised input level.
  output logic busy_out, // Conversion in progress.
  output logic track_out, // High in track, low in hold.
  output logic sleep_out, // Part asleep.
  output logic clk_pad_en_out, // Conversion clock pad open.
  output logic [RES-1:0] result_bus_out, // Result data.
  output logic result_bus_oe_out, // Result bus driven.
  output sadc_pkg::sadc_state_t state_out // Sequencer state.
);
  import sadc_pkg::*;

  localparam int CONV_CYC = (RES == 12) ? `SADC_CONV_CYC_12 :
                            `SADC_CONV_CYC_10;
  localparam int WAKE_CYC = `SADC_WAKE_NS / `SADC_CLK_PERIOD_NS;
  localparam int GAP_CYC = (`SADC_CLK_GAP_NS + `SADC_CLK_PERIOD_NS - 1) /
                           `SADC_CLK_PERIOD_NS;
  localparam int CW = $clog2(WAKE_CYC + 1);
  localparam int EW = $clog2(CONV_CYC + 1);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  initial begin
    if (RES != 10 && RES != 12) begin
      $error("sadc_ctrl: RES must be 10 or 12");
    end
    if (FIFO_DEPTH < 2) begin
      $error("sadc_ctrl: FIFO_DEPTH must be at least 2");
    end
  end

  typedef struct packed {
    sadc_state_t state;
    logic start_d;
    logic clk_d;
    logic busy;
    logic track;
    logic sleep;
    logic oe;
    logic pad_en;
    logic [RES-1:0] held;
    logic [RES-1:0] sar;
    logic [RES-1:0] out;
    logic [EW-1:0] edges;
    logic [CW-1:0] cnt;
  } sadc_st_t;

  sadc_st_t r_reg;
  sadc_st_t r_next;
  logic start_fall;
  logic start_rise;
  logic clk_rise;
  logic bus_en;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [RES-1:0] pop_data;
  logic [LW-1:0] fifo_level;

  // Inputs are synchronous, so edges come from one registered copy.
  assign start_fall = r_reg.start_d & ~conversion_start_n_in;
  assign start_rise = ~r_reg.start_d & conversion_start_n_in;
  assign clk_rise = ~r_reg.clk_d & conv_clk_in & r_reg.pad_en;
  assign bus_en = ~(select_n_in | read_n_in);

  // The output register holds still during a read so the host sees a
  // steady word; the finishing conversion overrides that hold.
  assign pop_ready = ~bus_en | (r_reg.state == SADC_LOAD);
  assign push_valid = (r_reg.state == SADC_PUSH);

  sadc_fifo #(
    .WIDTH(RES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(r_reg.sar),
    .out_valid_out(pop_valid),
    .out_ready_in(pop_ready),
    .out_data_out(pop_data),
    .level_out(fifo_level)
  );

  // Sequencer, approximation register and output register.
  always_comb begin
    r_next = r_reg;
    r_next.start_d = conversion_start_n_in;
    r_next.clk_d = conv_clk_in;
    r_next.oe = bus_en;
    if (pop_valid && pop_ready) begin
      r_next.out = pop_data;
    end
    case (r_reg.state)
      SADC_IDLE: begin
        if (start_fall) begin
          r_next.state = SADC_CONV;
          r_next.track = 1'b0;
          r_next.busy = 1'b1;
          r_next.held = analog_code_in;
          r_next.sar = '0;
          r_next.edges = '0;
          r_next.cnt = CW'(GAP_CYC);
          r_next.pad_en = 1'b1;
        end
      end
      SADC_CONV: begin
        // The first system cycle after the edge ignores the clock pin.
        if (r_reg.cnt != '0) begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end else if (clk_rise) begin
          r_next.edges = r_reg.edges + 1'b1;
          // One bit decided per clock over the first RES clocks, most significant first.
          for (int i = 0; i < RES; i++) begin
            if (i == RES - 1 - int'(r_reg.edges)) begin
              r_next.sar[i] = ((r_reg.sar | (RES'(1) << i)) <= r_reg.held);
            end
          end
          if (int'(r_reg.edges) == CONV_CYC - 1) begin
            r_next.state = SADC_PUSH;
            r_next.pad_en = 1'b0;
          end
        end
      end
      SADC_PUSH: begin
        // A full buffer stalls completion and keeps busy high.
        if (push_ready) begin
          r_next.state = SADC_LOAD;
          r_next.track = 1'b1;
        end
      end
      SADC_LOAD: begin
        if (pop_valid && fifo_level == LW'(1)) begin
          r_next.state = SADC_FIN;
        end
      end
      SADC_FIN: begin
        r_next.busy = 1'b0;
        if (!conversion_start_n_in) begin
          r_next.state = SADC_SLEEP;
          r_next.sleep = 1'b1;
        end else begin
          r_next.state = SADC_IDLE;
        end
      end
      SADC_SLEEP: begin
        if (start_rise) begin
          r_next.state = SADC_WAKE;
          r_next.sleep = 1'b0;
          r_next.cnt = CW'(WAKE_CYC - 1);
        end
      end
      SADC_WAKE: begin
        // Starts during wake-up are ignored; the analog side is not ready.
        if (r_reg.cnt == '0) begin
          r_next.state = SADC_IDLE;
        end else begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      default: begin
        r_next.state = SADC_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      r_reg <= '0;
      r_reg.state <= SADC_IDLE;
      r_reg.start_d <= `SADC_RST_START_N;
      r_reg.track <= `SADC_RST_TRACK;
    end else begin
      r_reg <= r_next;
    end
  end

  // Every output is a flip-flop of the state record.
  assign busy_out = r_reg.busy;
  assign track_out = r_reg.track;
  assign sleep_out = r_reg.sleep;
  assign clk_pad_en_out = r_reg.pad_en;
  assign result_bus_out = r_reg.out;
  assign result_bus_oe_out = r_reg.oe;
  assign state_out = r_reg.state;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_oe_both_low: assert property (
    (!select_n_in && !read_n_in) |=> result_bus_oe_out)
    else $error("bus not driven after select and read low");

  a_oe_select_high: assert property (
    select_n_in |=> !result_bus_oe_out)
    else $error("bus driven with select high");

  a_oe_read_high: assert property (
    read_n_in |=> !result_bus_oe_out)
    else $error("bus driven with read high");

  a_start_holds: assert property (
    (r_reg.state == SADC_IDLE && start_fall) |=>
      (busy_out && !track_out && clk_pad_en_out))
    else $error("start edge did not begin conversion");

  a_busy_during_conv: assert property (
    (r_reg.state inside {SADC_CONV, SADC_PUSH, SADC_LOAD}) |-> busy_out)
    else $error("busy low during conversion");

  a_busy_fall_loaded: assert property (
    $fell(busy_out) |-> ($past(r_reg.state, 2) == SADC_LOAD &&
      result_bus_out == $past(r_reg.sar, 2)))
    else $error("busy fell before result loaded");

  a_track_before_fall: assert property (
    $fell(busy_out) |-> ($past(track_out) && track_out))
    else $error("track not resumed before busy fell");

  a_sleep_entry: assert property (
    ($fell(busy_out) && !$past(conversion_start_n_in)) |-> sleep_out)
    else $error("no sleep with start still low");

  a_wake_rise: assert property (
    (r_reg.state == SADC_SLEEP && start_rise) |=>
      (!sleep_out ##(WAKE_CYC) r_reg.state == SADC_IDLE))
    else $error("wake-up sequence wrong");

  a_pad_only_conv: assert property (
    clk_pad_en_out |-> (r_reg.state == SADC_CONV))
    else $error("clock pad open outside conversion");

  a_conv_length: assert property (
    (r_reg.state == SADC_PUSH && $past(r_reg.state) == SADC_CONV) |->
      (int'(r_reg.edges) == CONV_CYC))
    else $error("wrong conversion clock count");
endmodule

// *** sadc_params.svh ***
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// Clock period of clk_sys_in in nanoseconds.
`define SADC_CLK_PERIOD_NS 20
// Wake-up time after leaving sleep, in nanoseconds.
`define SADC_WAKE_NS 1000
// Least gap between start and first conversion clock pulse, in ns.
`define SADC_CLK_GAP_NS 10
// Conversion clock cycles for the 12-bit and 10-bit variants.
`define SADC_CONV_CYC_12 14
`define SADC_CONV_CYC_10 12
// Default resolution and result buffer depth.
`define SADC_RES_DEFAULT 12
`define SADC_FIFO_DEPTH 32
// Reset values of the pin-facing flags.
`define SADC_RST_START_N 1'b1
`define SADC_RST_TRACK 1'b1

`endif

// *** sadc_pkg.sv ***
package sadc_pkg;
  // Control sequencer states.
  typedef enum logic [2:0] {
    SADC_IDLE,
    SADC_CONV,
    SADC_PUSH,
    SADC_LOAD,
    SADC_FIN,
    SADC_SLEEP,
    SADC_WAKE
  } sadc_state_t;
endpackage

// *** sadc_host_model.sv ***
`timescale 1ns/100ps
`include "sadc_params.svh"

// Host conversion clock source. It runs only while busy is high and stands
// still low otherwise, like a host that gates its clock between frames.
module sadc_host_model (
  input wire logic clk_sys_in, // System clock.
  input wire logic busy_in, // Busy flag from the converter.
  input wire logic slow_in, // Stretch the clock period.
  output logic conv_clk_out // Conversion clock to the converter.
);
  int phase = 0;

  // The first rise comes two cycles after busy, four when slow, far past the start gap.
  // An unknown busy before reset counts as idle, so the clock stays low.
  always @(negedge clk_sys_in) begin
    if (busy_in !== 1'b1) begin
      conv_clk_out <= 1'b0;
      phase <= 0;
    end else if (phase >= (slow_in ? 3 : 1)) begin
      conv_clk_out <= !conv_clk_out;
      phase <= 0;
    end else begin
      phase <= phase + 1;
    end
  end
endmodule

// *** sadc_ctrl_bench.sv ***
`timescale 1ns/100ps
`include "sadc_params.svh"

module sadc_ctrl_bench;
  import sadc_pkg::*;
  localparam int RES = 12;
  localparam int CYC = `SADC_CONV_CYC_12;
  logic clk_sys_in, reset_in, start_n, conv_clk, sel_n, rd_n, slow;
  logic busy, track, sleep, pad, oe, conv_prev;
  logic [RES-1:0] code, bus;
  logic [15:0] lfsr;
  sadc_state_t state;
  int errors, checked, edges;
  int q[$];

  sadc_ctrl #(.RES(RES), .FIFO_DEPTH(`SADC_FIFO_DEPTH)) DUT (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .conversion_start_n_in(start_n), .conv_clk_in(conv_clk),
    .select_n_in(sel_n), .read_n_in(rd_n), .analog_code_in(code),
    .busy_out(busy), .track_out(track), .sleep_out(sleep),
    .clk_pad_en_out(pad), .result_bus_out(bus),
    .result_bus_oe_out(oe), .state_out(state));

  sadc_host_model host (.clk_sys_in(clk_sys_in), .busy_in(busy),
    .slow_in(slow), .conv_clk_out(conv_clk));

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = !clk_sys_in;
  end

  // Counts conversion clock rises seen while the pad is open.
  always @(posedge clk_sys_in) begin
    conv_prev <= conv_clk;
    if (pad === 1'b1 && conv_clk && !conv_prev) edges <= edges + 1;
  end

  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Reference successive approximation with a plain trial comparison.
  function automatic int sar_model(input int level);
    int acc;
    acc = 0;
    for (int b = RES - 1; b >= 0; b--)
      if ((acc | (1 << b)) <= level) acc = acc | (1 << b);
    return acc;
  endfunction

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [RES-1:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One conversion; stay_low keeps the start strobe low through the end.
  // The edge counter runs freely; each conversion counts from a base.
  task automatic convert(input bit stay_low);
    int n;
    int base;
    logic [RES-1:0] exp;
    logic [RES-1:0] pre;
    lfsr = next_rand(lfsr);
    @(negedge clk_sys_in);
    code = lfsr[RES-1:0];
    exp = RES'(sar_model(int'(code)));
    q.push_back(int'(exp));
    @(negedge clk_sys_in);
    start_n = 1'b0;
    base = edges;
    n = 0;
    while (busy !== 1'b1 && n < 3) begin
      @(negedge clk_sys_in);
      n++;
    end
    check_bit(busy, 1'b1);
    check_bit(track, 1'b0);
    check_bit(pad, 1'b1);
    if (!stay_low) begin
      @(negedge clk_sys_in);
      start_n = 1'b1;
    end
    n = 0;
    // Pre keeps the bus as it stood in the last cycle with busy high.
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      if (busy === 1'b1) pre = bus;
      n++;
    end
    check_bit(busy, 1'b0);
    check_bit((edges - base) == CYC, 1'b1);
    check_bit(track, 1'b1);
    check_bit(pad, 1'b0);
    check_bit(sleep, stay_low);
    check_bit(state === (stay_low ? SADC_SLEEP : SADC_IDLE), 1'b1);
    if (sel_n === 1'b0 && rd_n === 1'b0) begin
      check_bit(oe, 1'b1);
      check_word(pre, exp);
      check_word(bus, exp);
      void'(q.pop_front());
    end
  endtask

  // Read with select first, then read strobe, then select released.
  task automatic read_result(input logic [RES-1:0] exp);
    @(negedge clk_sys_in);
    sel_n = 1'b0;
    @(negedge clk_sys_in);
    check_bit(oe, 1'b0);
    rd_n = 1'b0;
    @(negedge clk_sys_in);
    check_bit(oe, 1'b1);
    check_word(bus, exp);
    sel_n = 1'b1;
    @(negedge clk_sys_in);
    check_bit(oe, 1'b0);
    rd_n = 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    summarize();
  end

  initial begin
    reset_in = 1'b1;
    start_n = 1'b1;
    sel_n = 1'b1;
    rd_n = 1'b1;
    slow = 1'b0;
    code = '0;
    lfsr = 16'h0005;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_in = 1'b0;
    check_bit(busy, 1'b0);
    check_bit(track, 1'b1);
    check_bit(sleep, 1'b0);
    check_bit(pad, 1'b0);
    check_bit(state === SADC_IDLE, 1'b1);
    check_word(bus, '0);
    check_bit(oe, 1'b0);
    $display("test reset done");
    // One dummy conversion after power-up; its result is thrown away.
    convert(1'b0);
    void'(q.pop_front());
    // Plain conversions at both clock rates, each read back.
    for (int i = 0; i < 6; i++) begin
      slow = i[0];
      convert(1'b0);
      read_result(RES'(q.pop_front()));
    end
    $display("test convert done");
    // Auto sleep, then wake on the rising start edge.
    convert(1'b1);
    @(negedge clk_sys_in);
    start_n = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check_bit(sleep, 1'b0);
    // Give the part its wake-up time before the next start.
    repeat (52) @(negedge clk_sys_in);
    read_result(RES'(q.pop_front()));
    convert(1'b0);
    read_result(RES'(q.pop_front()));
    $display("test sleep done");
    // Select and read held low: the bus tracks every new result.
    @(negedge clk_sys_in);
    sel_n = 1'b0;
    rd_n = 1'b0;
    for (int i = 0; i < 3; i++) convert(1'b0);
    sel_n = 1'b1;
    rd_n = 1'b1;
    $display("test held bus done");
    summarize();
  end
endmodule
